// ==== logic/switch_fault_protection_autoretry.v ====
// Fault protection, fault pin and autoretry for a dual high-side switch
// What this block does
// - Overtemp while on latches output off
// - Overtemp latch released by retry, toggle, reset
// - Overtemp while off: pin low, unlatched
// - Overtemp flag set, cleared by read
// - Four-level profile, lamp bit picks bulb
// - Clear rise or retry restarts inrush profile
// - Slope field; skip bit drops first step
// - Steady level select, second level default
// - Overcurrent latches off, pin, flag
// - Cooling: first step from prior off time
// - Short latches off; release by toggle, reset or wipe, never retry
// - Overvoltage off all outputs, disable bit
// - Overvoltage flag read-clears once gone
// - Undervoltage off, pin low, flag set
// - Recovery while off releases pin
// - Recovery while on stays latched off
// - Extended range keeps faults and outputs
// - Supply fail without undervoltage clears all latched faults
// - Retry request is OC or OT or UV
// - Retry each period, sixteen tries max
// - Mode change clears retry counters
// - Each retry restores inrush profile
// - Clear command is input or on bit
// - Flags kept until first status read
`timescale 1ns/10ps
`include "fault_protect_map.vh"
module switch_fault_protection_autoretry #(
    parameter [15:0] AUTO_CYCLES = `AUTO_CYCLES,
    parameter [15:0] STEP_CYCLES = `STEP_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [1:0] direct_in,
    input wire [1:0] overtemp_cmp,
    input wire [1:0] overcurrent_cmp,
    input wire [1:0] short_cmp,
    input wire overvoltage_cmp,
    input wire undervoltage_cmp,
    input wire logic_supply_fail,
    input wire extended_range,
    input wire supply_below_min,
    input wire fail_safe,
    output reg [1:0] switch_output,
    output reg fault_indicator_n,
    output reg [2:0] oc_level0,
    output reg [2:0] oc_level1,
    output reg oc_profile_bulb
);

// ****************
// Helpers
// ****************

// Step length scaled by a two-bit slope code
function [15:0] slope_len;
    input [1:0] sel;
    begin
        slope_len = STEP_CYCLES * ({14'h0000, sel} + 16'h0001);
    end
endfunction

// Level code: high steps 0..2, steady 4..7
function [2:0] level_code;
    input [1:0] step;
    input [1:0] steady;
    begin
        if (step != `STEADY_STEP) begin
            level_code = {1'b0, step};
        end else begin
            // Default 00 picks the second low level
            case (steady)
                2'h0: level_code = 3'h5;
                2'h1: level_code = 3'h4;
                2'h2: level_code = 3'h6;
                default: level_code = 3'h7;
            endcase
        end
    end
endfunction

// ****************
// Input synchronisers
// ****************
reg [15:0] sync1_reg; // First stage only
reg [15:0] sync2_reg; // Stable copies
wire [1:0] in_s = sync2_reg[1:0];
wire [1:0] ot_s = sync2_reg[3:2];
wire [1:0] oc_s = sync2_reg[5:4];
wire [1:0] sc_s = sync2_reg[7:6];
wire ov_s = sync2_reg[8];
wire uv_s = sync2_reg[9];
wire vdd_fail_s = sync2_reg[10];
wire ext_s = sync2_reg[11];
wire low_s = sync2_reg[12];
wire fs_s = sync2_reg[13];

// Two flops on every pin
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sync1_reg <= 16'h0000;
        sync2_reg <= 16'h0000;
    end else begin
        sync1_reg <= {2'b00, fail_safe, supply_below_min, extended_range,
                      logic_supply_fail, undervoltage_cmp, overvoltage_cmp,
                      short_cmp, overcurrent_cmp, overtemp_cmp, direct_in};
        sync2_reg <= sync1_reg;
    end
end

// ****************
// Bus slave
// ****************
reg [15:0] ctrl_reg; // Control word
reg [7:0] flags_reg; // Sticky fault flags
reg [7:0] flags_next;
reg [1:0] ot_lat_reg; // Overtemp latches
reg [1:0] oc_lat_reg; // Overcurrent latches
reg [1:0] sc_lat_reg; // Short latches
reg [1:0] uv_lat_reg; // Undervoltage latches
reg [4:0] retry0_reg; // Retry tries, output 0
reg [4:0] retry1_reg; // Retry tries, output 1
wire take = hsel & htrans[1] & hready; // Address phase taken
wire rd_status = take & ~hwrite & (haddr == `STATUS_OFS);
reg wr_pend_reg; // Write data phase due
reg [7:0] wr_addr_reg; // Its address

// Read data built from live state
reg [31:0] rdata_next;
always @* begin
    case (haddr)
        `CTRL_OFS: rdata_next = {16'h0000, ctrl_reg};
        `STATUS_OFS: rdata_next = {24'h00_0000, flags_reg};
        `STATE_OFS: rdata_next = {17'h0_0000, ~fs_s, retry1_reg, retry0_reg,
                                  ot_lat_reg | oc_lat_reg | sc_lat_reg | uv_lat_reg,
                                  switch_output};
        default: rdata_next = 32'h0000_0000;
    endcase
end

// Zero-wait responses, writes land in data phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        ctrl_reg <= `CTRL_RST;
    end else begin
        wr_pend_reg <= take & hwrite;
        wr_addr_reg <= haddr;
        // Read data latched at address phase
        if (take & ~hwrite) begin
            hrdata <= rdata_next;
        end
        // Fail-safe forces defaults
        if (fs_s) begin
            ctrl_reg <= `CTRL_RST;
        end else if (wr_pend_reg && wr_addr_reg == `CTRL_OFS) begin
            ctrl_reg <= hwdata[15:0];
        end
    end
end

// ****************
// Per-output command and events
// ****************
wire [1:0] on_bit = ctrl_reg[`C_ON];
wire [1:0] dir_en = ctrl_reg[`C_DIR];
wire pwm_en = ctrl_reg[`C_PWM];
wire ov_act = ov_s & ~ctrl_reg[`C_OVDIS];
reg [1:0] cmd; // Fault clear command
reg [1:0] cmd_prev_reg; // Previous command
reg fs_prev_reg; // Previous mode
wire [1:0] rise = cmd & ~cmd_prev_reg; // Off-on toggle
wire mode_chg = fs_s ^ fs_prev_reg; // Either direction
wire wipe = mode_chg | (vdd_fail_s & ~uv_s);
wire [1:0] retry_req = flags_reg[`S_OC] | flags_reg[`S_OT] | {2{flags_reg[`S_UV]}};
wire [1:0] any_lat = ot_lat_reg | oc_lat_reg | sc_lat_reg | uv_lat_reg;
wire [1:0] soft_lat = ot_lat_reg | oc_lat_reg | uv_lat_reg;
wire [1:0] rel_ok = rise & ~ot_s & ~sc_s & {2{~uv_s}};
reg [1:0] retry_go; // Autoretry fires
reg [15:0] auto0_reg; // Retry timer 0
reg [15:0] auto1_reg; // Retry timer 1
wire [4:0] retry_cnt [0:1];
wire [15:0] auto_cnt [0:1];
assign retry_cnt[0] = retry0_reg;
assign retry_cnt[1] = retry1_reg;
assign auto_cnt[0] = auto0_reg;
assign auto_cnt[1] = auto1_reg;
integer i; // Loop index, command process
integer j; // Loop index, latch process
integer k; // Loop index, output process

// Command: direct input without PWM, or on bit
always @* begin
    for (i = 0; i < 2; i = i + 1) begin
        cmd[i] = (in_s[i] & dir_en[i] & ~pwm_en) | on_bit[i];
        // Fail-safe: outputs follow the inputs
        if (fs_s) begin
            cmd[i] = in_s[i];
        end
        // Timer done, overtemp and undervoltage gone, tries left
        retry_go[i] = soft_lat[i] & ~sc_lat_reg[i] & retry_req[i]
                      & (auto_cnt[i] == AUTO_CYCLES - 16'h0001)
                      & ~ot_s[i] & ~uv_s & (retry_cnt[i] < `RETRY_MAX);
    end
end

// ****************
// Latches and retry counters
// ****************
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ot_lat_reg <= 2'b00;
        oc_lat_reg <= 2'b00;
        sc_lat_reg <= 2'b00;
        uv_lat_reg <= 2'b00;
        retry0_reg <= 5'h00;
        retry1_reg <= 5'h00;
        auto0_reg <= 16'h0000;
        auto1_reg <= 16'h0000;
        cmd_prev_reg <= 2'b00;
        fs_prev_reg <= 1'b0;
    end else begin
        cmd_prev_reg <= cmd;
        fs_prev_reg <= fs_s;
        // Retry timers run only while a retry waits
        auto0_reg <= (soft_lat[0] & retry_req[0] & ~retry_go[0]) ? auto0_reg + 16'h0001 : 16'h0000;
        auto1_reg <= (soft_lat[1] & retry_req[1] & ~retry_go[1]) ? auto1_reg + 16'h0001 : 16'h0000;
        if (wipe) begin
            ot_lat_reg <= 2'b00;
            oc_lat_reg <= 2'b00;
            sc_lat_reg <= 2'b00;
            uv_lat_reg <= 2'b00;
            retry0_reg <= 5'h00;
            retry1_reg <= 5'h00;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                // Toggle release clears everything
                if (rel_ok[j]) begin
                    ot_lat_reg[j] <= 1'b0;
                    oc_lat_reg[j] <= 1'b0;
                    sc_lat_reg[j] <= 1'b0;
                    uv_lat_reg[j] <= 1'b0;
                end else if (retry_go[j]) begin
                    ot_lat_reg[j] <= 1'b0;
                    oc_lat_reg[j] <= 1'b0;
                    uv_lat_reg[j] <= 1'b0;
                end else begin
                    // Overtemp latches only while commanded on
                    if (ot_s[j] & cmd[j]) ot_lat_reg[j] <= 1'b1;
                    if (oc_s[j] & switch_output[j]) oc_lat_reg[j] <= 1'b1;
                    if (sc_s[j] & switch_output[j]) sc_lat_reg[j] <= 1'b1;
                    // Undervoltage latches only when commanded on
                    if (uv_s & cmd[j] & ~ext_s) uv_lat_reg[j] <= 1'b1;
                end
            end
            // Tries counted per output
            if (rel_ok[0]) retry0_reg <= 5'h00;
            else if (retry_go[0]) retry0_reg <= retry0_reg + 5'h01;
            if (rel_ok[1]) retry1_reg <= 5'h00;
            else if (retry_go[1]) retry1_reg <= retry1_reg + 5'h01;
        end
    end
end

// ****************
// Sticky flags
// ****************
always @* begin
    flags_next = flags_reg;
    // Status read clears, set below wins
    if (rd_status) begin
        flags_next[`S_OT] = 2'b00;
        flags_next[`S_OC] = 2'b00;
        flags_next[`S_SC] = 2'b00;
        flags_next[`S_UV] = 1'b0;
        if (!ov_s) flags_next[`S_OV] = 1'b0;
    end
    flags_next[`S_OT] = flags_next[`S_OT] | ot_s;
    flags_next[`S_OC] = flags_next[`S_OC] | (oc_s & switch_output);
    flags_next[`S_SC] = flags_next[`S_SC] | (sc_s & switch_output);
    flags_next[`S_OV] = flags_next[`S_OV] | ov_s;
    flags_next[`S_UV] = flags_next[`S_UV] | uv_s;
    if (wipe) begin
        flags_next = 8'h00;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        flags_reg <= 8'h00;
    end else begin
        flags_reg <= flags_next;
    end
end

// ****************
// Overcurrent profile
// ****************
reg [1:0] step0_reg; // Profile step 0
reg [1:0] step1_reg; // Profile step 1
reg [15:0] stime0_reg; // Step timer 0
reg [15:0] stime1_reg; // Step timer 1
reg [15:0] off0_reg; // Off time 0
reg [15:0] off1_reg; // Off time 1
wire [1:0] restart = rise | retry_go;
wire cool_on = ~fs_s & pwm_en & ctrl_reg[`C_COOL] & ctrl_reg[`C_LAMP];
wire [15:0] step_len = slope_len(ctrl_reg[`C_SLOPE]);
wire [15:0] cool_len = slope_len(ctrl_reg[`C_CSLOPE]);
wire [1:0] first_step = ctrl_reg[`C_SKIP] ? 2'h1 : 2'h0;

// Warm filament skips early high steps
function [1:0] start_step;
    input [15:0] off_time;
    begin
        if (cool_on && off_time < cool_len) start_step = 2'h2;
        else if (cool_on && off_time < {cool_len[14:0], 1'b0}) start_step = 2'h1;
        else start_step = first_step;
        if (start_step < first_step) start_step = first_step;
    end
endfunction

// Step walk toward steady level
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        step0_reg <= 2'h0;
        step1_reg <= 2'h0;
        stime0_reg <= 16'h0000;
        stime1_reg <= 16'h0000;
        off0_reg <= 16'h0000;
        off1_reg <= 16'h0000;
    end else begin
        // Off time saturates
        off0_reg <= switch_output[0] ? 16'h0000 : (&off0_reg ? off0_reg : off0_reg + 16'h0001);
        off1_reg <= switch_output[1] ? 16'h0000 : (&off1_reg ? off1_reg : off1_reg + 16'h0001);
        if (restart[0]) begin
            step0_reg <= start_step(off0_reg);
            stime0_reg <= 16'h0000;
        end else if (step0_reg != `STEADY_STEP && switch_output[0]) begin
            stime0_reg <= (stime0_reg == step_len - 16'h0001) ? 16'h0000 : stime0_reg + 16'h0001;
            if (stime0_reg == step_len - 16'h0001) step0_reg <= step0_reg + 2'h1;
        end
        if (restart[1]) begin
            step1_reg <= start_step(off1_reg);
            stime1_reg <= 16'h0000;
        end else if (step1_reg != `STEADY_STEP && switch_output[1]) begin
            stime1_reg <= (stime1_reg == step_len - 16'h0001) ? 16'h0000 : stime1_reg + 16'h0001;
            if (stime1_reg == step_len - 16'h0001) step1_reg <= step1_reg + 2'h1;
        end
    end
end

// ****************
// Outputs and fault pin
// ****************
reg [1:0] sw_next;
reg pin_low;
always @* begin
    for (k = 0; k < 2; k = k + 1) begin
        if (ext_s) begin
            // Extended range holds state, overtemp still acts
            sw_next[k] = switch_output[k] & ~low_s & ~ot_s[k];
        end else begin
            sw_next[k] = cmd[k] & ~any_lat[k] & ~ot_s[k] & ~ov_act & ~uv_s;
        end
    end
    // Latched faults, live overtemp when off, supply faults
    pin_low = (|any_lat) | (|(ot_s & ~cmd)) | ov_act | uv_s;
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        switch_output <= 2'b00;
        fault_indicator_n <= 1'b1;
        oc_level0 <= 3'h0;
        oc_level1 <= 3'h0;
        oc_profile_bulb <= 1'b0;
    end else begin
        switch_output <= sw_next;
        fault_indicator_n <= ~pin_low;
        oc_level0 <= level_code(step0_reg, ctrl_reg[`C_STEADY]);
        oc_level1 <= level_code(step1_reg, ctrl_reg[`C_STEADY]);
        oc_profile_bulb <= ctrl_reg[`C_LAMP];
    end
end

endmodule

// ==== logic/fault_protect_map.vh ====
// Register map and timing constants for the switch fault protection block
`ifndef FAULT_PROTECT_MAP_VH
`define FAULT_PROTECT_MAP_VH
// ****************
// Register offsets
// ****************
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define STATE_OFS 8'h08
`define CTRL_RST 16'h0000
// ****************
// Control fields
// ****************
`define C_ON 1:0
`define C_DIR 3:2
`define C_PWM 4
`define C_LAMP 5
`define C_SLOPE 7:6
`define C_SKIP 8
`define C_STEADY 10:9
`define C_COOL 11
`define C_CSLOPE 13:12
`define C_OVDIS 14
// ****************
// Status fields
// ****************
`define S_OT 1:0
`define S_OC 3:2
`define S_SC 5:4
`define S_OV 6
`define S_UV 7
// ****************
// Timing
// ****************
`define CLK_MHZ 20
`define AUTO_US 1000
`define AUTO_CYCLES (`AUTO_US * `CLK_MHZ)
`define STEP_US 100
`define STEP_CYCLES (`STEP_US * `CLK_MHZ)
`define RETRY_MAX 5'h10
`define STEADY_STEP 2'h3
`endif

// ==== test/fault_protect_checker.sv ====
// Concurrent checks on the pin reactions of the switch fault block
`timescale 1ns/10ps
module fault_protect_checker (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire [1:0] overtemp_cmp,
    input wire [1:0] overcurrent_cmp,
    input wire [1:0] short_cmp,
    input wire undervoltage_cmp,
    input wire extended_range,
    input wire [1:0] switch_output,
    input wire fault_indicator_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****************
    // Held conditions
    // ****************
    // Overcurrent seen while output 0 drives
    sequence s_oc_on;
        overcurrent_cmp[0] && switch_output[0] && !extended_range;
    endsequence
    // Output 1 hot while idle, long enough to pass the syncs
    sequence s_ot_idle;
        (overtemp_cmp[1] && !switch_output[1])[*4];
    endsequence
    // Supply low long enough to pass the syncs
    sequence s_uv_held;
        (undervoltage_cmp && !extended_range)[*4];
    endsequence
    // ****************
    // Assertions
    // ****************
    chk_oc_off: assert property (s_oc_on |-> ##[1:4] !switch_output[0])
        else $error("overcurrent left output on");
    chk_oc_pin: assert property (s_oc_on |-> ##[1:4] !fault_indicator_n)
        else $error("overcurrent left fault pin high");
    chk_oc_hold: assert property ($fell(switch_output[0]) && overcurrent_cmp[0] |=> (!switch_output[0])[*3])
        else $error("overcurrent latch did not hold");
    chk_short_off: assert property (short_cmp[0] && switch_output[0] && !extended_range |-> ##[1:4] !switch_output[0])
        else $error("short left output on");
    chk_ot_latch: assert property (overtemp_cmp[0] && switch_output[0] && !extended_range |-> ##[1:4] (!switch_output[0] && !fault_indicator_n))
        else $error("overtemp did not latch off");
    chk_ot_idle: assert property (s_ot_idle |-> !fault_indicator_n)
        else $error("overtemp while off left pin high");
    chk_uv_off: assert property (s_uv_held |-> switch_output == 2'h0 && !fault_indicator_n)
        else $error("undervoltage left outputs on");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
endmodule
bind switch_fault_protection_autoretry fault_protect_checker chk_u (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .overtemp_cmp(overtemp_cmp),
    .overcurrent_cmp(overcurrent_cmp), .short_cmp(short_cmp), .undervoltage_cmp(undervoltage_cmp),
    .extended_range(extended_range), .switch_output(switch_output), .fault_indicator_n(fault_indicator_n)
);

// ==== test/host_bus_model.sv ====
// Host side bus master that reads and writes the fault block
`timescale 1ns/10ps
module host_bus_model (
    input wire hclk,
    input wire hreadyout,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'h0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // One single word transfer; status reads drain the fault flags
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        q = hrdata;
        hsel <= 1'h0;
        hwdata <= ~d;
    endtask
endmodule

// ==== test/switch_fault_protection_autoretry_tb_top.sv ====
// Self-checking bench of the switch fault block
`timescale 1ns/10ps
`include "fault_protect_map.vh"
module switch_fault_protection_autoretry_tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ovc, uvc, lsf, ext, bmin, fsafe, fault_indicator_n, bulb;
    logic [7:0] haddr;
    logic [1:0] htrans, din, otc, ocm, scm, switch_output;
    logic [2:0] hsize, lvl0, lvl1;
    logic [31:0] hwdata, hrdata, st_m, c, q;
    logic ov_now;
    int n_fail, n_compared, cyc;
    int lv[4] = '{5, 4, 6, 7};
    // ****************
    // Instances
    // ****************
    switch_fault_protection_autoretry #(.AUTO_CYCLES(16'h0014), .STEP_CYCLES(16'h0005)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .direct_in(din), .overtemp_cmp(otc), .overcurrent_cmp(ocm), .short_cmp(scm),
        .overvoltage_cmp(ovc), .undervoltage_cmp(uvc), .logic_supply_fail(lsf), .extended_range(ext),
        .supply_below_min(bmin), .fail_safe(fsafe), .switch_output(switch_output),
        .fault_indicator_n(fault_indicator_n), .oc_level0(lvl0), .oc_level1(lvl1), .oc_profile_bulb(bulb));
    host_bus_model host_u (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ****************
    // Helpers
    // ****************
    initial begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end
    // Cut a hang short
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host_u.xfer(a, 1'h1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(a, 1'h0, 32'h0000_0000, q);
        check(q, e);
    endtask
    // Status read against the flag model; overvoltage stays while present
    task automatic rd_status();
        rd(`STATUS_OFS, st_m);
        st_m = ov_now ? (st_m & 32'h0000_0040) : 32'h0000_0000;
    endtask
    task automatic toggle_on(input logic [31:0] d);
        wr(`CTRL_OFS, 32'h0000_0000);
        wr(`CTRL_OFS, d);
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {hresetn, din, otc, ocm, scm, ovc, uvc, lsf, ext, bmin, fsafe, ov_now} = '0;
        {n_fail, n_compared, cyc} = '0;
        st_m = 32'h0000_0000;
        wt(20);
        hresetn <= 1'h1;
        void'($urandom(32'hf2e7));
        rd(`CTRL_OFS, 32'h0000_0000);
        rd(8'h0c, 32'h0000_0000);
        rd(`STATE_OFS, 32'h0000_4000);
        // Overtemp on a driving output and on an idle one
        toggle_on(32'h0000_0001);
        wt(5);
        otc <= 2'h3;
        wt(5);
        check(switch_output, 2'h0);
        otc <= 2'h0;
        st_m = 32'h0000_0003;
        wt(5);
        check(fault_indicator_n, 1'h0);
        rd_status();
        rd_status();
        toggle_on(32'h0000_0001);
        wt(4);
        check(switch_output, 2'h1);
        // Overcurrent held until retries run out
        ocm <= 2'h1;
        wt(5);
        check(fault_indicator_n, 1'h0);
        wt(800);
        rd(`STATE_OFS, 32'h0000_4104);
        st_m = 32'h0000_0004;
        rd_status();
        ocm <= 2'h0;
        fsafe <= 1'h1;
        wt(5);
        fsafe <= 1'h0;
        wt(5);
        rd(`STATE_OFS, 32'h0000_4000);
        rd(`CTRL_OFS, 32'h0000_0000);
        // Profile fields with random slope, skip and lamp bits
        for (int s = 0; s < 4; s++) begin
            c = (s << 9) | ($urandom & 32'h0000_01e0) | 32'h0000_0001;
            toggle_on(c);
            wt(3);
            check(lvl0, c[8] ? 3'h1 : 3'h0);
            check(bulb, c[5]);
            check(lvl1, 3'h0);
            wt(90);
            check(lvl0, lv[s]);
        end
        // Severe short never retries
        toggle_on(32'h0000_0001);
        scm <= 2'h1;
        wt(40);
        check(switch_output, 2'h0);
        st_m = 32'h0000_0010;
        rd_status();
        scm <= 2'h0;
        toggle_on(32'h0000_0003);
        wt(4);
        check(switch_output, 2'h3);
        // Overvoltage, enabled then disabled
        ovc <= 1'h1;
        ov_now = 1'h1;
        wt(5);
        check(switch_output, 2'h0);
        st_m = 32'h0000_0040;
        rd_status();
        rd_status();
        ovc <= 1'h0;
        ov_now = 1'h0;
        wt(5);
        check(switch_output, 2'h3);
        rd_status();
        rd_status();
        wr(`CTRL_OFS, 32'h0000_4003);
        ovc <= 1'h1;
        wt(5);
        check(switch_output, 2'h3);
        ovc <= 1'h0;
        wt(5);
        st_m = 32'h0000_0040;
        rd_status();
        // Undervoltage while commanded on, then logic supply loss
        uvc <= 1'h1;
        wt(5);
        check(switch_output, 2'h0);
        uvc <= 1'h0;
        wt(5);
        check(fault_indicator_n, 1'h0);
        st_m = 32'h0000_0080;
        rd_status();
        lsf <= 1'h1;
        wt(5);
        lsf <= 1'h0;
        wt(5);
        host_u.xfer(`STATE_OFS, 1'h0, 32'h0000_0000, q);
        check(q & 32'h0000_000c, 32'h0000_0000);
        // Extended range keeps outputs until the supply drops too low
        wt(5);
        ext <= 1'h1;
        uvc <= 1'h1;
        wt(5);
        check(switch_output, 2'h3);
        bmin <= 1'h1;
        wt(5);
        check(switch_output, 2'h0);
        {ext, uvc, bmin} <= 3'h0;
        wt(5);
        conclude();
    end
endmodule
